// file: design/dpc_dual_counter.sv
// dual pulse counter top: two 16-bit counters, chainable to 32 bits
// assumes pins synchronous-safe via input stage, sampleTick from 32 kHz
//
// Overview of operation
// - rising edge if select 0, falling if 1
// - debounce codes 0..3 mean 0,2,4,8 samples
// - chaining makes one 32-bit counter via zero
// - per counter enable gates compare interrupt
// - interrupt when count becomes reference plus one
// - reference kept in sleep; interrupt can wake
// - reference 16 or 32 bits, writable anytime
// - counting wraps to zero past maximum
// - start adds no spurious count
// - stop freezes count, still readable
// - status bits 22 and 23 report reached
// - status bit cleared once reported
// - live 16-bit counts readable undisturbed
// - live 32-bit count and chained flag visible
// - unchained: per counter clear resets own count only
// - chained: separate clear resets whole 32-bit count
// - counter zero pin one, counter one pin eight
// - chained mode uses only counter zero config
// - no debounce counts without slow oscillator
`timescale 1ns/10ps
module dpc_dual_counter (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic                  gpioInputOne,
    input  wire logic                  gpioInputEight,
    input  wire logic                  sampleTick,
    input  wire logic                  chainCounters,
    input  wire dpc_pkg::dpc_cfg_type  cfgZero,
    input  wire dpc_pkg::dpc_cfg_type  cfgOne,
    input  wire dpc_pkg::dpc_ctl_type  ctlZero,
    input  wire dpc_pkg::dpc_ctl_type  ctlOne,
    input  wire logic                  clearWide,
    input  wire logic                  refWriteZero,
    input  wire logic                  refWriteOne,
    input  wire logic [31:0]           compareReference,
    input  wire logic                  statusRead,
    output logic [31:0]                statusWord,
    output logic [15:0]                countZero,
    output logic [15:0]                countOne,
    output logic [31:0]                countWide,
    output logic                       chainedActive,
    output logic                       runningZero,
    output logic                       runningOne,
    output logic                       compareIrq
);
    import dpc_pkg::*;

    logic [31:0] refZero;
    logic [15:0] refOne;
    logic        reachedZero;
    logic        reachedOne;
    logic        edgeZero;
    logic        edgeOne;
    logic        incZero;
    logic        incOne;
    logic        carryIntoOne;
    logic [15:0] next_countZero;
    logic [15:0] next_countOne;
    logic        hitZero;
    logic        hitOne;
    logic [31:0] wideNext;
    logic [31:0] refPlusOne;
    logic [15:0] refOnePlusOne;
    logic        clrZero;
    logic        clrOne;

    // ----------------------------------------
    // input stages
    // ----------------------------------------
    dpc_input_stage u_stageZero (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .pinIn      (gpioInputOne),
        .sampleTick (sampleTick),
        .cfg        (cfgZero),
        .countEdge  (edgeZero)
    );

    dpc_input_stage u_stageOne (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .pinIn      (gpioInputEight),
        .sampleTick (sampleTick),
        .cfg        (cfgOne),
        .countEdge  (edgeOne)
    );

    // ----------------------------------------
    // count decode
    // ----------------------------------------
    assign chainedActive = chainCounters;
    assign incZero       = runningZero && edgeZero;
    assign carryIntoOne  = incZero && (countZero == CNT_MAX);
    // chained: counter one follows zero's carry, its own pin ignored
    assign incOne        = chainCounters ? carryIntoOne : (runningOne && edgeOne);
    assign next_countZero = countZero + 16'h0001;
    assign next_countOne  = countOne + 16'h0001;
    assign countWide      = {countOne, countZero};
    assign wideNext       = countWide + 32'h0000_0001;
    assign refPlusOne     = refZero + 32'h0000_0001;
    assign refOnePlusOne  = refOne + 16'h0001;
    assign clrZero        = (!chainCounters && ctlZero.clear)
                            || (chainCounters && clearWide);
    assign clrOne         = (!chainCounters && ctlOne.clear)
                            || (chainCounters && clearWide);

    // reached only on the incrementing edge that lands on ref plus one
    assign hitZero = chainCounters ? (incZero && wideNext == refPlusOne)
                                   : (incZero && next_countZero == refPlusOne[15:0]);
    assign hitOne  = !chainCounters && incOne && (next_countOne == refOnePlusOne);

    // ----------------------------------------
    // run control
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            runningZero <= 1'b0;
            runningOne  <= 1'b0;
        end else begin
            if (ctlZero.start)
                runningZero <= 1'b1;
            else if (ctlZero.stop)
                runningZero <= 1'b0;
            if (ctlOne.start)
                runningOne <= 1'b1;
            else if (ctlOne.stop)
                runningOne <= 1'b0;
        end
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    // an edge in the same cycle as a start is not counted: the running flag sets one cycle later
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            countZero <= CNT_ZERO;
            countOne  <= CNT_ZERO;
        end else begin
            if (clrZero)
                countZero <= CNT_ZERO;
            else if (incZero)
                countZero <= next_countZero;
            if (clrOne)
                countOne <= CNT_ZERO;
            else if (incOne)
                countOne <= next_countOne;
        end
    end

    // ----------------------------------------
    // reference
    // ----------------------------------------
    // plain flops, no reset path other than power-on: kept through sleep
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            refZero <= WIDE_ZERO;
            refOne  <= CNT_ZERO;
        end else begin
            if (refWriteZero)
                refZero <= chainCounters ? compareReference
                                         : {CNT_ZERO, compareReference[15:0]};
            if (refWriteOne)
                refOne <= compareReference[15:0];
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    // a new hit wins over the read-clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reachedZero <= 1'b0;
            reachedOne  <= 1'b0;
        end else begin
            if (hitZero)
                reachedZero <= 1'b1;
            else if (statusRead)
                reachedZero <= 1'b0;
            if (hitOne)
                reachedOne <= 1'b1;
            else if (statusRead)
                reachedOne <= 1'b0;
        end
    end

    always_comb begin
        statusWord                = WIDE_ZERO;
        statusWord[STATUS_BIT_C0] = reachedZero;
        statusWord[STATUS_BIT_C1] = reachedOne;
    end

    // level request usable as a wake source while the core sleeps
    assign compareIrq = (reachedZero && cfgZero.compareIrqEnable)
                      || (reachedOne && cfgOne.compareIrqEnable && !chainCounters);

endmodule : dpc_dual_counter

// file: design/dpc_pkg.sv
// dual pulse counter package: constants, config and control carriers
// assumes a 50 MHz core clock and a 32 kHz sample tick from outside
package dpc_pkg;

    localparam int          CNT_W          = 16;
    localparam int          WIDE_W         = 32;
    localparam logic [15:0] CNT_MAX        = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO       = 16'h0000;
    localparam logic [31:0] WIDE_ZERO      = 32'h0000_0000;
    localparam int          STATUS_BIT_C0  = 22;
    localparam int          STATUS_BIT_C1  = 23;
    localparam logic        EDGE_RISING    = 1'b0;
    localparam logic        EDGE_FALLING   = 1'b1;
    localparam logic [3:0]  DEB_RUN_ONE    = 4'h1;
    localparam logic [3:0]  DEB_NEED_2     = 4'h2;
    localparam logic [3:0]  DEB_NEED_4     = 4'h4;
    localparam logic [3:0]  DEB_NEED_8     = 4'h8;
    localparam int          CORE_CLK_HZ    = 50_000_000;

    typedef enum logic [1:0] {
        DPC_DEB_NONE = 2'b00,
        DPC_DEB_2    = 2'b01,
        DPC_DEB_4    = 2'b10,
        DPC_DEB_8    = 2'b11
    } dpc_deb_type;

    typedef struct packed {
        logic        edgeSelect;
        dpc_deb_type debounceSampleCode;
        logic        compareIrqEnable;
    } dpc_cfg_type;

    typedef struct packed {
        logic start;
        logic stop;
        logic clear;
    } dpc_ctl_type;

endpackage : dpc_pkg

// file: design/dpc_input_stage.sv
// dual pulse counter input stage: synchroniser, debounce, edge pick
// assumes sampleTick is a one-cycle pulse at the slow oscillator rate
`timescale 1ns/10ps
module dpc_input_stage (
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               pinIn,
    input  wire logic               sampleTick,
    input  wire dpc_pkg::dpc_cfg_type cfg,
    output logic                    countEdge
);
    import dpc_pkg::*;

    logic       syncFirst;
    logic       syncSecond;
    logic       accepted;
    logic       runLevel;
    logic [3:0] runCount;
    logic [3:0] needCount;
    logic       bypass;
    logic       next_accepted;
    logic       sameLevel;

    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncFirst  <= 1'b0;
            syncSecond <= 1'b0;
        end else begin
            syncFirst  <= pinIn;
            syncSecond <= syncFirst;
        end
    end

    // ----------------------------------------
    // debounce
    // ----------------------------------------
    assign bypass    = (cfg.debounceSampleCode == DPC_DEB_NONE);
    assign needCount = (cfg.debounceSampleCode == DPC_DEB_2) ? DEB_NEED_2 :
                       (cfg.debounceSampleCode == DPC_DEB_4) ? DEB_NEED_4 : DEB_NEED_8;
    assign sameLevel = (syncSecond == runLevel);
    assign next_accepted = bypass ? syncSecond :
                           (sampleTick && sameLevel && runCount >= needCount - DEB_RUN_ONE)
                           ? syncSecond : accepted;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            runLevel <= 1'b0;
            runCount <= 4'h0;
            accepted <= 1'b0;
        end else begin
            accepted <= next_accepted;
            if (sampleTick) begin
                runLevel <= syncSecond;
                if (!sameLevel)
                    runCount <= DEB_RUN_ONE;
                else if (runCount != DEB_NEED_8)
                    runCount <= runCount + DEB_RUN_ONE;
            end
        end
    end

    // ----------------------------------------
    // edge select
    // ----------------------------------------
    assign countEdge = (cfg.edgeSelect == EDGE_RISING) ? (next_accepted && !accepted)
                                                       : (!next_accepted && accepted);

endmodule : dpc_input_stage

// file: verification/dpc_dual_counter_asserts.sv
// checker: port relations of the dual pulse counter
// assumes it is bound onto dpc_dual_counter
`timescale 1ns/10ps
module dpc_dual_counter_asserts
    import dpc_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 reset_n,
    input wire logic                 chainCounters,
    input wire dpc_pkg::dpc_cfg_type cfgZero,
    input wire dpc_pkg::dpc_cfg_type cfgOne,
    input wire dpc_pkg::dpc_ctl_type ctlZero,
    input wire dpc_pkg::dpc_ctl_type ctlOne,
    input wire logic                 clearWide,
    input wire logic                 refWriteZero,
    input wire logic [31:0]          compareReference,
    input wire logic                 statusRead,
    input wire logic [31:0]          statusWord,
    input wire logic [15:0]          countZero,
    input wire logic [15:0]          countOne,
    input wire logic [31:0]          countWide,
    input wire logic                 chainedActive,
    input wire logic                 runningZero,
    input wire logic                 compareIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] refZero;
    wire logic [15:0] refNext = refZero + 16'h0001;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            refZero <= CNT_ZERO;
        else if (refWriteZero)
            refZero <= compareReference[15:0];
    end
    chk_chain_flag: assert property (chainedActive == chainCounters)
        else $error("chained flag differs from setting");
    chk_wide_pair: assert property (countWide == {countOne, countZero})
        else $error("wide count is not the two halves");
    chk_stop_hold: assert property (!runningZero && !ctlZero.start && !ctlZero.clear
        && !clearWide |=> $stable(countZero)) else $error("stopped count moved");
    chk_start_run: assert property (ctlZero.start |=> runningZero)
        else $error("start did not run the counter");
    chk_clear_own: assert property (!chainCounters && ctlOne.clear |=> countOne == CNT_ZERO)
        else $error("own clear missed");
    chk_clear_wide: assert property (chainCounters && clearWide |=> countWide == WIDE_ZERO)
        else $error("wide clear missed");
    chk_irq_gate: assert property (compareIrq == (statusWord[22] && cfgZero.compareIrqEnable
        || statusWord[23] && cfgOne.compareIrqEnable && !chainCounters))
        else $error("interrupt not gated");
    chk_read_clear: assert property (statusRead && statusWord[22] ##1 $stable(countZero)
        |-> !statusWord[22]) else $error("reported flag not cleared");
    chk_hit_flag: assert property (!chainCounters && countZero == refNext
        && countZero == $past(countZero) + 16'h0001 && !$past(ctlZero.clear)
        && !$past(refWriteZero) |-> ##[0:1] statusWord[22])
        else $error("reference pass not flagged");
    cover property (statusRead && statusWord[22]);
    cover property (chainCounters && clearWide);
    cover property (compareIrq);
endmodule : dpc_dual_counter_asserts
bind dpc_dual_counter dpc_dual_counter_asserts u_chk (.core_clk, .reset_n, .chainCounters,
    .cfgZero, .cfgOne, .ctlZero, .ctlOne, .clearWide, .refWriteZero, .compareReference,
    .statusRead, .statusWord, .countZero, .countOne, .countWide, .chainedActive,
    .runningZero, .compareIrq);

// file: verification/dpc_pulse_source.sv
// partner: external pulse source on both counter pins
// assumes the bench calls setLevel; pins idle low
`timescale 1ns/10ps
module dpc_pulse_source (
    input  wire logic core_clk,
    output logic      pinOne,
    output logic      pinEight
);
    initial begin
        pinOne = 1'b0;
        pinEight = 1'b0;
    end
    // hold keeps the pulse rate inside the debounce limit
    task automatic setLevel(input logic a, input logic b, input int hold);
        @(posedge core_clk);
        pinOne <= a;
        pinEight <= b;
        repeat (hold) @(posedge core_clk);
        @(negedge core_clk);
    endtask : setLevel
endmodule : dpc_pulse_source

// file: verification/dpc_dual_counter_tb_top.sv
// bench: dual pulse counter against an integer model
// assumes dpc_pulse_source drives pins and the checker is bound
`timescale 1ns/10ps
module dpc_dual_counter_tb_top;
    import dpc_pkg::*;
    localparam int HOLD = 250;
    logic core_clk, reset_n, gpioInputOne, gpioInputEight, sampleTick, chainCounters;
    logic clearWide, refWriteZero, refWriteOne, statusRead, chainedActive;
    logic runningZero, runningOne, compareIrq;
    logic [2:0] tickCnt;
    logic [31:0] compareReference, statusWord, countWide;
    logic [15:0] countZero, countOne;
    dpc_cfg_type cfgZero, cfgOne;
    dpc_ctl_type ctlZero, ctlOne;
    int error_cnt, tests_run, expZero, expOne, expWide, n, r, h;
    bit on0;
    dpc_pulse_source u_src (.core_clk, .pinOne(gpioInputOne), .pinEight(gpioInputEight));
    dpc_dual_counter u_dut (.core_clk, .reset_n, .gpioInputOne, .gpioInputEight, .sampleTick,
        .chainCounters, .cfgZero, .cfgOne, .ctlZero, .ctlOne, .clearWide, .refWriteZero,
        .refWriteOne, .compareReference, .statusRead, .statusWord, .countZero, .countOne,
        .countWide, .chainedActive, .runningZero, .runningOne, .compareIrq);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        tickCnt <= tickCnt + 3'h1;
        sampleTick <= &tickCnt;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic strobe(input dpc_ctl_type c0, input dpc_ctl_type c1, input logic [3:0] m);
        @(posedge core_clk);
        ctlZero <= c0;
        ctlOne <= c1;
        {clearWide, refWriteZero, refWriteOne, statusRead} <= m;
        @(posedge core_clk);
        ctlZero <= 3'h0;
        ctlOne <= 3'h0;
        {clearWide, refWriteZero, refWriteOne, statusRead} <= 4'h0;
        @(negedge core_clk);
    endtask : strobe
    task automatic pulses(input int k, input logic a, input logic b);
        repeat (k) begin
            u_src.setLevel(a, b, HOLD);
            u_src.setLevel(1'b0, 1'b0, HOLD);
            expZero += int'(a & on0);
            expOne += int'(b);
            expWide += int'(a & on0);
        end
    endtask : pulses
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        {reset_n, chainCounters, clearWide, refWriteZero, refWriteOne, statusRead} = 6'h0;
        {ctlZero, ctlOne, cfgZero, cfgOne, tickCnt, sampleTick} = 18'h0;
        compareReference = 32'h0;
        on0 = 1'b1;
        n = $urandom(14);
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        check(countWide, 32'h0);
        cfgZero <= 4'h1;
        cfgOne <= 4'h8;
        strobe(3'h4, 3'h4, 4'h0);
        check(32'(countZero > 16'h0001), 32'h0);
        strobe(3'h1, 3'h1, 4'h0);
        n = $urandom_range(5, 2);
        for (int i = 0; i < n; i++) begin
            u_src.setLevel(1'b1, 1'b1, HOLD);
            expZero++;
            check(countWide, {expOne[15:0], expZero[15:0]});
            u_src.setLevel(1'b0, 1'b0, HOLD);
            expOne++;
            check(countWide, {expOne[15:0], expZero[15:0]});
        end
        check(32'({statusWord[23:22], compareIrq}), 32'h7);
        $display("test edges done");
        strobe(3'h0, 3'h0, 4'h1);
        for (int e = 1; e >= 0; e--) begin
            cfgZero.compareIrqEnable <= e[0];
            r = expZero + 2 - e;
            compareReference <= {16'($urandom()), r[15:0]};
            strobe(3'h0, 3'h0, 4'h6);
            for (int p = 0; p < 3 - e; p++) begin
                pulses(1, 1'b1, 1'b0);
                h = (expZero == r + 1);
                check(32'({statusWord[23:22], compareIrq}), {29'h0, 1'b0, h[0], h[0] & e[0]});
            end
            strobe(3'h0, 3'h0, 4'h1);
            check(32'(statusWord[22]), 32'h0);
        end
        $display("test reference done");
        for (int d = 1; d < 4; d++) begin
            cfgZero <= {1'b0, d[1:0], 1'b0};
            u_src.setLevel(1'b1, 1'b0, 2);
            u_src.setLevel(1'b0, 1'b0, HOLD);
            pulses(1, 1'b1, 1'b0);
            check(32'(countZero), expZero);
        end
        $display("test debounce done");
        strobe(3'h2, 3'h0, 4'h0);
        on0 = 1'b0;
        pulses(2, 1'b1, 1'b1);
        check(countWide, {expOne[15:0], expZero[15:0]});
        check(32'({runningZero, runningOne}), 32'h1);
        $display("test stop done");
        chainCounters <= 1'b1;
        cfgOne <= 4'hE;
        on0 = 1'b1;
        strobe(3'h4, 3'h0, 4'h0);
        strobe(3'h0, 3'h0, 4'h8);
        expWide = 0;
        compareReference <= 32'h0000_0002;
        strobe(3'h0, 3'h0, 4'h4);
        pulses(3, 1'b1, 1'b1);
        check(countWide, expWide);
        check(32'({statusWord[23:22], compareIrq}), 32'h2);
        check(32'(chainedActive), 32'h1);
        strobe(3'h1, 3'h1, 4'h0);
        check(countWide, expWide);
        strobe(3'h0, 3'h0, 4'h8);
        check(countWide, 32'h0);
        $display("test chain done");
        end_of_test();
    end
endmodule : dpc_dual_counter_tb_top
